// file: core/rfl_pkg.sv
/*
 * Shared constants, types and functions of the RTU serial framer.
 * Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package rfl_pkg;
    typedef logic [31:0] rfl_word_t;

    // Register byte offsets and address regions.
    localparam logic [9:0] A_CTRL = 10'h000;
    localparam logic [9:0] A_STAT = 10'h004;
    localparam logic [9:0] A_TXGO = 10'h008;
    localparam logic [1:0] RGN_REG = 2'h0;
    localparam logic [1:0] RGN_RX = 2'h1;
    localparam logic [1:0] RGN_TX = 2'h2;

    // Bit timing.
    localparam int CLK_HZ = 100000000;
    localparam int BAUD_DEF = 9600;
    localparam logic [15:0] DIV_DEF = 16'(CLK_HZ / BAUD_DEF);

    // Character format.
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [3:0] CHR_LEN7 = 4'ha;
    localparam logic [3:0] CHR_LEN8 = 4'hb;

    // Gaps in half characters: 1.5 and 3.5 character times.
    localparam logic [7:0] GAP_DROP_X2 = 8'h03;
    localparam logic [7:0] GAP_END_X2 = 8'h07;

    // Frame check and addressing.
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [7:0] ADDR_BCAST = 8'h00;
    localparam logic [7:0] STATION_RST = 8'h01;
    localparam logic [7:0] MIN_FRAME = 8'h04;
    localparam logic [7:0] MIN_TX = 8'h02;

    // Sticky status flag positions.
    localparam int F_DONE = 0;
    localparam int F_CRC = 1;
    localparam int F_PAR = 2;
    localparam int F_DROP = 3;
    localparam int F_BCAST = 4;

    typedef struct packed {
        logic [7:0] station;
        logic [4:0] rsv;
        logic seven;
        logic [1:0] par;
        logic [15:0] div;
    } rfl_ctrl_t;

    typedef struct packed {
        logic [15:0] rsv;
        logic [7:0] rx_len;
        logic [1:0] rsv2;
        logic tx_busy;
        logic [4:0] flags;
    } rfl_stat_t;

    localparam rfl_ctrl_t CTRL_RST = '{station: STATION_RST, rsv: 5'h00, seven: 1'b0,
                                       par: PAR_EVEN, div: DIV_DEF};

    function automatic logic [15:0] rfl_crc_step(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    function automatic logic rfl_par_bit(input logic [7:0] d, input logic [1:0] mode);
        return (^d) ^ (mode == PAR_ODD);
    endfunction
endpackage

// file: core/rfl_link.sv
/*
 * RTU serial framer: character engine, gap timing, frame check and an AHB-Lite register slave.
 * Assumes one master on a zero-wait AHB-Lite bus and an external half-duplex line driver.
 */
// Decided for this implementation: the AHB-Lite register port and the address map.
// Behaviour
// - 8 data bits: 11-bit character
// - 7 data bits: 10-bit character
// - LSB first; two end bits without parity
// - 3.5 character silence before any frame; the code also starts a frame on the character that drops a held partial frame
// - Address, function, data, check field order
// - 3.5 character silence ends a frame
// - Frame characters sent back to back; the code holds the end bit one extra bit time before each next character
// - Gap over 1.5 drops partial frame
// - Merged frames report a check fault
// - Address 0 to 247, 0 broadcasts
// - No response to broadcast requests
// - Function 03H reads, 06H writes
// - Data field two bytes per word
// - Check value low byte first
// - Parity even, odd or none
// - Even parity bit set on odd ones
// - Odd parity bit set on even ones
// - Received parity mismatch flags an error
// - Received check mismatch flags an error
// - Check register preset to ffff
// - Only data bits of frame bytes checked
// - Byte xor, eight shifts, poly a001
module rfl_link #(
    parameter int DEPTH = 64,
    parameter logic [15:0] DIV_RST = rfl_pkg::DIV_DEF
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire rfl_pkg::rfl_word_t haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire rfl_pkg::rfl_word_t hwdata,
    input wire logic hready,
    output rfl_pkg::rfl_word_t hrdata,
    output logic hreadyout,
    output logic hresp,
    // Serial line.
    input wire logic rxd,
    output logic txd,
    output logic tx_en
);
    import rfl_pkg::*;

    localparam int AW = $clog2(DEPTH);

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rfl_rx_t;
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} rfl_tx_t;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    rfl_ctrl_t ctrl_ff;
    logic [4:0] flags_ff;
    logic [7:0] rx_mem [DEPTH];
    logic [7:0] tx_mem [DEPTH];

    // Bus address and data phase.
    logic acc;
    logic wr_ff;
    logic rd_ff;
    logic rdy_ff;
    logic [9:0] wa_ff;
    rfl_word_t hrdata_ff;
    rfl_word_t rd_word;
    logic [AW-1:0] widx;

    assign acc = hsel & hready & htrans[1];
    assign widx = wa_ff[AW+1:2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            rdy_ff <= 1'b1;
            wa_ff <= 10'h000;
        end else begin
            wr_ff <= acc & hwrite;
            rd_ff <= acc & ~hwrite;
            // Reads take one wait state because the read data is registered in hrdata_ff before it is driven.
            rdy_ff <= ~(acc & ~hwrite);
            if (acc) begin
                wa_ff <= haddr[9:0];
            end
        end
    end

    // Receiver character engine.
    rfl_rx_t rx_st_ff;
    logic [15:0] rcnt_ff;
    logic [3:0] rbit_ff;
    logic [8:0] rsh_ff;
    logic ch_ff;
    logic ch_bad_ff;
    logic [7:0] ch_byte_ff;
    logic [3:0] nbits;
    logic [3:0] chr;
    logic [8:0] rfield;
    logic [7:0] rbyte;
    logic rpar;
    logic [15:0] div_m1;

    assign div_m1 = ctrl_ff.div - 16'h0001;
    assign chr = ctrl_ff.seven ? CHR_LEN7 : CHR_LEN8;
    assign nbits = (ctrl_ff.seven ? 4'h7 : 4'h8) + ((ctrl_ff.par != PAR_NONE) ? 4'h1 : 4'h0);
    assign rfield = rsh_ff >> (4'h9 - nbits);
    assign rbyte = ctrl_ff.seven ? {1'b0, rfield[6:0]} : rfield[7:0];
    assign rpar = ctrl_ff.seven ? rfield[7] : rfield[8];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_st_ff <= RX_IDLE;
            rcnt_ff <= 16'h0000;
            rbit_ff <= 4'h0;
            rsh_ff <= 9'h000;
            ch_ff <= 1'b0;
            ch_bad_ff <= 1'b0;
            ch_byte_ff <= 8'h00;
        end else begin
            ch_ff <= 1'b0;
            rcnt_ff <= rcnt_ff + 16'h0001;
            case (rx_st_ff)
                RX_IDLE: begin
                    rcnt_ff <= 16'h0000;
                    if (!rxd) begin
                        rx_st_ff <= RX_START;
                    end
                end
                RX_START: begin
                    if (rcnt_ff >= (ctrl_ff.div >> 1)) begin
                        rcnt_ff <= 16'h0000;
                        rbit_ff <= 4'h0;
                        rx_st_ff <= rxd ? RX_IDLE : RX_BITS;
                    end
                end
                RX_BITS: begin
                    if (rcnt_ff >= div_m1) begin
                        rcnt_ff <= 16'h0000;
                        rsh_ff <= {rxd, rsh_ff[8:1]};
                        rbit_ff <= rbit_ff + 4'h1;
                        if (rbit_ff == nbits - 4'h1) begin
                            rx_st_ff <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rcnt_ff >= div_m1) begin
                        rx_st_ff <= RX_IDLE;
                        ch_ff <= 1'b1;
                        ch_byte_ff <= rbyte;
                        // A bad end bit is reported together with parity faults.
                        ch_bad_ff <= ~rxd | ((ctrl_ff.par != PAR_NONE) &&
                                             (rpar != rfl_par_bit(rbyte, ctrl_ff.par)));
                    end
                end
                default: rx_st_ff <= RX_IDLE;
            endcase
        end
    end

    // Bit tick and line silence counter.
    logic [15:0] tdiv_ff;
    logic tick_ff;
    logic [6:0] gap_ff;
    logic [7:0] gx2;
    logic drop_hit;
    logic end_hit;

    assign gx2 = {gap_ff, 1'b0};
    assign drop_hit = gx2 > GAP_DROP_X2 * {4'h0, chr};
    assign end_hit = gx2 >= GAP_END_X2 * {4'h0, chr};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tdiv_ff <= 16'h0000;
            tick_ff <= 1'b0;
            gap_ff <= 7'h00;
        end else begin
            tick_ff <= tdiv_ff >= div_m1;
            tdiv_ff <= (tdiv_ff >= div_m1) ? 16'h0000 : tdiv_ff + 16'h0001;
            if (ch_ff || rx_st_ff != RX_IDLE || tx_en) begin
                gap_ff <= 7'h00;
            end else if (tick_ff && gap_ff != 7'h7f) begin
                gap_ff <= gap_ff + 7'h01;
            end
        end
    end

    // Receive frame assembly and check.
    logic in_ff;
    logic held_ff;
    logic armed_ff;
    logic perr_ff;
    logic ovf_ff;
    logic [AW:0] rlen_ff;
    logic [15:0] rcrc_ff;
    logic [7:0] rlen_rd_ff;
    logic start_new;
    logic append;
    logic fin;
    logic mine;
    logic [4:0] set_f;
    logic [4:0] clr_f;

    assign append = ch_ff & in_ff & ~held_ff;
    assign start_new = ch_ff & (held_ff | (~in_ff & armed_ff));
    assign fin = held_ff & end_hit & ~ch_ff;
    assign mine = (rx_mem[0] == ctrl_ff.station) || (rx_mem[0] == ADDR_BCAST);

    always_comb begin
        set_f = 5'h00;
        set_f[F_DROP] = ch_ff & held_ff;
        if (fin && mine) begin
            set_f[F_DONE] = 1'b1;
            set_f[F_CRC] = (rcrc_ff != 16'h0000) || ({{(7 - AW){1'b0}}, rlen_ff} < MIN_FRAME) || ovf_ff;
            set_f[F_PAR] = perr_ff;
            set_f[F_BCAST] = rx_mem[0] == ADDR_BCAST;
        end
        clr_f = (wr_ff && wa_ff == A_STAT) ? hwdata[4:0] : 5'h00;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_ff <= 1'b0;
            held_ff <= 1'b0;
            armed_ff <= 1'b0;
            perr_ff <= 1'b0;
            ovf_ff <= 1'b0;
            rlen_ff <= '0;
            rcrc_ff <= CRC_INIT;
            rlen_rd_ff <= 8'h00;
            flags_ff <= 5'h00;
        end else begin
            // A flag raised in the same cycle as its clear stays raised.
            flags_ff <= (flags_ff & ~clr_f) | set_f;
            if (start_new) begin
                in_ff <= 1'b1;
                held_ff <= 1'b0;
                armed_ff <= 1'b0;
                perr_ff <= ch_bad_ff;
                ovf_ff <= 1'b0;
                rlen_ff <= {{AW{1'b0}}, 1'b1};
                rcrc_ff <= rfl_crc_step(CRC_INIT, ch_byte_ff);
            end else if (append) begin
                perr_ff <= perr_ff | ch_bad_ff;
                rcrc_ff <= rfl_crc_step(rcrc_ff, ch_byte_ff);
                if (rlen_ff == DEPTH[AW:0]) begin
                    ovf_ff <= 1'b1;
                end else begin
                    rlen_ff <= rlen_ff + {{AW{1'b0}}, 1'b1};
                end
            end else if (in_ff && !held_ff && drop_hit) begin
                held_ff <= 1'b1;
            end else if (fin) begin
                in_ff <= 1'b0;
                held_ff <= 1'b0;
                armed_ff <= 1'b1;
                if (mine) begin
                    rlen_rd_ff <= 8'(rlen_ff);
                end
            end else if (!in_ff && end_hit) begin
                armed_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk) begin
        if (start_new) begin
            rx_mem[0] <= ch_byte_ff;
        end else if (append && rlen_ff != DEPTH[AW:0]) begin
            rx_mem[rlen_ff[AW-1:0]] <= ch_byte_ff;
        end
        if (wr_ff && wa_ff[9:8] == RGN_TX) begin
            tx_mem[widx] <= hwdata[7:0];
        end
    end

    // Transmitter.
    rfl_tx_t tx_st_ff;
    logic [AW:0] tlen_ff;
    logic [AW+1:0] tidx_ff;
    logic [15:0] tcrc_ff;
    logic [11:0] tsh_ff;
    logic [3:0] tb_ff;
    logic txd_ff;
    logic tx_en_ff;
    logic go;
    logic load;
    logic last;
    logic [7:0] nb;
    logic [11:0] nf;
    logic pb;

    assign go = wr_ff && wa_ff == A_TXGO && tx_st_ff == TX_IDLE && !flags_ff[F_BCAST] &&
                hwdata[7:0] >= MIN_TX && hwdata[7:0] <= DEPTH[7:0];
    assign last = tidx_ff == {1'b0, tlen_ff} + {{AW{1'b0}}, 2'd2};
    assign load = (tx_st_ff == TX_WAIT && end_hit) ||
                  (tx_st_ff == TX_SEND && tick_ff && tb_ff == 4'h0 && !last);

    always_comb begin
        if (tidx_ff < {1'b0, tlen_ff}) begin
            nb = tx_mem[tidx_ff[AW-1:0]];
        end else if (tidx_ff == {1'b0, tlen_ff}) begin
            nb = tcrc_ff[7:0];
        end else begin
            nb = tcrc_ff[15:8];
        end
        // With seven data bits the unsent top bit must not reach parity or the check value.
        nb[7] = nb[7] & ~ctrl_ff.seven;
        pb = (ctrl_ff.par == PAR_NONE) ? 1'b1 : rfl_par_bit(nb, ctrl_ff.par);
        nf = ctrl_ff.seven ? {3'h7, pb, nb[6:0], 1'b0} : {2'h3, pb, nb, 1'b0};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_st_ff <= TX_IDLE;
            tlen_ff <= '0;
            tidx_ff <= '0;
            tcrc_ff <= CRC_INIT;
            tsh_ff <= 12'hfff;
            tb_ff <= 4'h0;
            txd_ff <= 1'b1;
            tx_en_ff <= 1'b0;
        end else begin
            if (go) begin
                tx_st_ff <= TX_WAIT;
                tlen_ff <= hwdata[AW:0];
                tidx_ff <= '0;
                tcrc_ff <= CRC_INIT;
            end
            if (load) begin
                tx_st_ff <= TX_SEND;
                tx_en_ff <= 1'b1;
                tsh_ff <= nf;
                tb_ff <= chr;
                tidx_ff <= tidx_ff + {{(AW + 1){1'b0}}, 1'b1};
                if (tidx_ff < {1'b0, tlen_ff}) begin
                    tcrc_ff <= rfl_crc_step(tcrc_ff, nb);
                end
            end else if (tx_st_ff == TX_SEND && tick_ff) begin
                if (tb_ff != 4'h0) begin
                    txd_ff <= tsh_ff[0];
                    tsh_ff <= {1'b1, tsh_ff[11:1]};
                    tb_ff <= tb_ff - 4'h1;
                end else begin
                    // The silence counter now runs, so the next frame waits its full gap.
                    tx_st_ff <= TX_IDLE;
                    tx_en_ff <= 1'b0;
                    txd_ff <= 1'b1;
                end
            end
        end
    end

    // Register writes and read mux.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= CTRL_RST;
            ctrl_ff.div <= DIV_RST;
        end else if (wr_ff && wa_ff == A_CTRL) begin
            ctrl_ff <= hwdata;
            ctrl_ff.rsv <= 5'h00;
        end
    end

    always_comb begin
        rd_word = '0;
        if (wa_ff == A_CTRL) begin
            rd_word = ctrl_ff;
        end else if (wa_ff == A_STAT) begin
            rd_word = rfl_stat_t'{rsv: 16'h0000, rx_len: rlen_rd_ff, rsv2: 2'h0,
                                  tx_busy: tx_st_ff != TX_IDLE, flags: flags_ff};
        end else if (wa_ff[9:8] == RGN_RX) begin
            rd_word = {24'h000000, rx_mem[widx]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= '0;
        end else if (rd_ff) begin
            hrdata_ff <= rd_word;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = rdy_ff;
    assign hresp = 1'b0;
    assign txd = txd_ff;
    assign tx_en = tx_en_ff;

    // Checks.
    par_flag_a: assert property (append && ch_bad_ff |=> perr_ff) else $error("parity fault lost");
    drop_flag_a: assert property (ch_ff && held_ff |=> flags_ff[F_DROP] && rlen_ff == 1)
        else $error("held frame not dropped");
    frame_end_a: assert property (fin |=> !in_ff && armed_ff) else $error("frame did not end");
    quiet_start_a: assert property (ch_ff && !in_ff && !armed_ff |=> !in_ff)
        else $error("frame began without silence");
    crc_seed_a: assert property (start_new |=> rcrc_ff == rfl_crc_step(16'hffff, $past(ch_byte_ff)))
        else $error("check not preset");
    crc_fault_a: assert property (fin && mine && rcrc_ff != 16'h0000 |=> flags_ff[F_CRC])
        else $error("check fault not flagged");
    bcast_quiet_a: assert property (wr_ff && wa_ff == A_TXGO && flags_ff[F_BCAST] && tx_st_ff == TX_IDLE
        |=> tx_st_ff == TX_IDLE) else $error("reply after broadcast");
    tx_gap_a: assert property ($rose(tx_en_ff) |-> $past(end_hit)) else $error("frame sent too soon");
    char_len_a: assert property (load |=> tb_ff == (ctrl_ff.seven ? 4'ha : 4'hb))
        else $error("wrong character length");
    start_bit_a: assert property (tx_st_ff == TX_SEND && tick_ff && !load && tb_ff == chr
        |=> !txd_ff ##1 !txd_ff [*2]) else $error("start bit wrong");

    frame_ok_c: cover property (fin && mine && rcrc_ff == 16'h0000);
    drop_c: cover property (ch_ff && held_ff);
    tx_done_c: cover property ($fell(tx_en_ff));
endmodule

// file: tb/rfl_line_master.sv
/*
 * Behavioural bus master on the serial line: sends request frames on rxd and collects characters from txd.
 * Assumes the bench sets the bit divisor, data width and parity mode to match the block's control register.
 */
module rfl_line_master import rfl_pkg::*; (
    // Clock.
    input wire logic hclk,
    // Line.
    input wire logic txd,
    input wire logic tx_en,
    output logic rxd,
    // Character format.
    input wire logic [15:0] div,
    input wire logic [1:0] par,
    input wire logic seven
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] got_q[$];
    int par_bad = 0;

    initial rxd = 1'b1;

    function automatic logic pbit(input logic [7:0] d, input logic [1:0] m);
        return (^d) ^ (m == PAR_ODD);
    endfunction

    task automatic put_bit(input logic v);
        rxd <= v;
        repeat (div) @(posedge hclk);
    endtask

    task automatic send_byte(input logic [7:0] d, input logic flip);
        put_bit(1'b0);
        for (int i = 0; i < 8 - seven; i++) put_bit(d[i]);
        if (par != PAR_NONE) put_bit(pbit(d, par) ^ flip);
        put_bit(1'b1);
        if (par == PAR_NONE) put_bit(1'b1);
    endtask

    // A flip index corrupts that byte's parity; a gap index pauses two characters before that byte.
    task automatic send_frame(input logic [7:0] f[$], input int flip_at, input int gap_at);
        repeat (44 * div) @(posedge hclk);
        foreach (f[i]) begin
            if (i == gap_at) repeat (22 * div) @(posedge hclk);
            send_byte(f[i], i == flip_at);
        end
        repeat (44 * div) @(posedge hclk);
    endtask

    // Each character is sampled at bit centres; a wrong parity or end bit is counted.
    always begin
        logic [7:0] d;
        @(negedge txd iff tx_en);
        d = 8'h00;
        repeat (div / 2) @(posedge hclk);
        for (int i = 0; i < 8 - seven; i++) begin
            repeat (div) @(posedge hclk);
            d[i] = txd;
        end
        if (par != PAR_NONE) begin
            repeat (div) @(posedge hclk);
            if (txd !== pbit(d, par)) par_bad++;
        end
        repeat (div) @(posedge hclk);
        if (txd !== 1'b1) par_bad++;
        got_q.push_back(d);
    end
endmodule

// file: tb/rfl_link_tb.sv
/*
 * Self-checking bench of the RTU serial framer: AHB-Lite register access, frame reception and transmission.
 * Assumes a 100 MHz clock and a bit divisor of 16 clocks to keep frames short.
 */
module rfl_link_tb import rfl_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    logic hclk = 1'b0;
    logic hresetn;
    logic hsel;
    rfl_word_t haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    rfl_word_t hwdata;
    rfl_word_t hrdata;
    logic hreadyout;
    logic hresp;
    logic rxd;
    logic txd;
    logic tx_en;
    logic [15:0] div;
    logic [1:0] par;
    logic seven;
    int err_total = 0;
    int comparisons = 0;
    logic [31:0] d, st, x;
    logic [7:0] f[$];
    logic [15:0] c;
    logic [1:0] pm;
    int idx[4] = '{F_DONE, F_CRC, F_PAR, F_BCAST};

    always #5 hclk = ~hclk;

    rfl_link #(.DEPTH(64), .DIV_RST(16'h0010)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rxd(rxd), .txd(txd), .tx_en(tx_en)
    );

    rfl_line_master i_master (.hclk(hclk), .txd(txd), .tx_en(tx_en), .rxd(rxd), .div(div), .par(par),
                              .seven(seven));

    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] r;
        r = 16'hffff;
        foreach (q[i]) begin
            r = r ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++) r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
        end
        return r;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        if (err_total == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Entered just after a rising edge; leaves just after the edge that completes the data phase.
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Sends one request, then reads and clears the sticky flags.
    task automatic rx_frame(input int flip_at, input int gap_at);
        i_master.send_frame(f, flip_at, gap_at);
        xfer(1'b0, 32'(A_STAT), 32'h0, st);
        // A reply request while the broadcast flag stands must be refused.
        if (st[F_BCAST] === 1'b1) begin
            xfer(1'b1, 32'(A_TXGO), 32'h2, x);
            xfer(1'b0, 32'(A_STAT), 32'h0, x);
            check("bcast txgo", {31'h0, x[5]}, 32'h0);
        end
        xfer(1'b1, 32'(A_STAT), 32'h1f, x);
    endtask

    initial begin
        repeat (80000) @(posedge hclk);
        err_total++;
        results();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        div = 16'h0010;
        par = PAR_EVEN;
        seven = 1'b0;
        void'($urandom(76));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, 32'(A_CTRL), 32'h0, d);
        check("ctrl reset", d, {8'h01, 5'h00, 1'b0, PAR_EVEN, 16'h0010});
        xfer(1'b0, 32'(A_STAT), 32'h0, d);
        check("stat reset", d, 32'h0);
        xfer(1'b0, 32'h3f0, 32'h0, d);
        check("unmapped", d, 32'h0);
        check("hresp", {31'h0, hresp}, 32'h0);
        // A character before the first full silence must be ignored.
        i_master.send_byte(8'h01, 1'b0);
        xfer(1'b0, 32'(A_STAT), 32'h0, d);
        check("early char", d, 32'h0);
        // Reference read request with its known check field.
        f = {8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02, 8'h85, 8'hca};
        rx_frame(-1, -1);
        check("ref done", {31'h0, st[F_DONE]}, 32'h1);
        check("ref crc", {31'h0, st[F_CRC]}, 32'h0);
        check("ref len", {24'h0, st[15:8]}, 32'h8);
        for (int i = 0; i < 6; i++) begin
            xfer(1'b0, 32'h100 + 4 * i, 32'h0, d);
            check("rx byte", {24'h0, d[7:0]}, {24'h0, f[i]});
        end
        // Same frame broken by a two-character pause.
        rx_frame(-1, 3);
        check("drop", {31'h0, st[F_DROP]}, 32'h1);
        // Two requests with no gap between them read as one frame with a bad check.
        f = {f, f};
        rx_frame(-1, -1);
        check("merged", {31'h0, st[F_CRC]}, 32'h1);
        // Random frames: good, bad check, bad parity, broadcast, across all parity modes.
        for (int k = 0; k < 4; k++) begin
            pm = (k == 2) ? PAR_ODD : ((k == 1) ? PAR_EVEN : PAR_NONE);
            par <= pm;
            xfer(1'b1, 32'(A_CTRL), {STATION_RST, 5'h00, 1'b0, pm, 16'h0010}, x);
            f = {(k == 3) ? 8'h00 : STATION_RST, (k % 2 == 1) ? 8'h06 : 8'h03};
            repeat (2 + 2 * ($urandom % 2)) f.push_back(8'($urandom));
            c = crc16(f);
            f.push_back(c[7:0]);
            f.push_back(c[15:8]);
            if (k == 1) f[f.size() - 1] = ~f[f.size() - 1];
            rx_frame((k == 2) ? 1 : -1, -1);
            check("rx flag", {31'h0, st[idx[k]]}, 32'h1);
            if (k == 0) check("rx len", {24'h0, st[15:8]}, 32'(f.size()));
        end
        check("no reply", {31'h0, tx_en}, 32'h0);
        // Transmission in every parity mode.
        for (int k = 0; k < 3; k++) begin
            pm = 2'(k);
            par <= pm;
            seven <= k == 1;
            xfer(1'b1, 32'(A_CTRL), {STATION_RST, 5'h00, k == 1, pm, 16'h0010}, x);
            f = {STATION_RST, 8'h03};
            repeat (2 * k + 2) f.push_back(8'($urandom) & ((k == 1) ? 8'h7f : 8'hff));
            foreach (f[i]) xfer(1'b1, 32'h200 + 4 * i, {24'h0, f[i]}, x);
            i_master.got_q.delete();
            xfer(1'b1, 32'(A_TXGO), 32'(f.size()), x);
            xfer(1'b0, 32'(A_STAT), 32'h0, st);
            check("tx busy", {31'h0, st[5]}, 32'h1);
            c = crc16(f);
            f.push_back(c[7:0]);
            f.push_back(c[15:8]);
            if (k == 1) foreach (f[i]) f[i][7] = 1'b0;
            for (int t = 0; t < 30000 && i_master.got_q.size() < f.size(); t++) @(posedge hclk);
            while (tx_en) @(posedge hclk);
            check("tx count", 32'(i_master.got_q.size()), 32'(f.size()));
            foreach (f[i]) check("tx byte", {24'h0, i_master.got_q[i]}, {24'h0, f[i]});
            check("tx format", 32'(i_master.par_bad), 32'h0);
        end
        results();
    end
endmodule
